// ===== spsc_pkg.sv
/*
  Package for the serial port status configuration bits block.
  Holds register offsets, bit positions, reset values and port mode codes.
  Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
package spsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] SPSC_STATUS_OFFSET = 4'h0;
  localparam logic [3:0] SPSC_MODE_OFFSET = 4'h4;
  localparam logic [7:0] SPSC_STATUS_RESET = 8'h00;
  localparam logic [1:0] SPSC_MODE_RESET = 2'h0;

  // ****************************************
  // Status register field positions
  // ****************************************
  localparam int SPSC_SAMPLE_BIT = 7;
  localparam int SPSC_EDGE_BIT = 6;
  localparam int SPSC_DATA_ADDR_BIT = 5;

  // ****************************************
  // Port mode codes
  // ****************************************
  localparam logic [1:0] SPSC_MODE_SPI_MASTER = 2'h0;
  localparam logic [1:0] SPSC_MODE_SPI_SLAVE = 2'h1;
  localparam logic [1:0] SPSC_MODE_I2C_MASTER = 2'h2;
  localparam logic [1:0] SPSC_MODE_I2C_SLAVE = 2'h3;

  // Bus slave states
  typedef enum logic [1:0] {
    SPSC_IDLE = 2'b01,
    SPSC_DONE = 2'b10
  } spsc_state_type;

endpackage

// ===== spsc_byte_kind.sv
/*
  Tracks whether the last byte moved on the I2C bus was data or an address.
  Assumes byte-done strobes from the shift engine are one-cycle pulses.
*/
`timescale 1ns/10ps
module spsc_byte_kind (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic i2c_active,
  input wire logic byte_done,
  input wire logic byte_is_data,
  output logic data_not_address
);
  import spsc_pkg::*;

  // Flag follows each completed byte while in I2C operation
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_not_address <= SPSC_STATUS_RESET[SPSC_DATA_ADDR_BIT];
    end else if (i2c_active && byte_done) begin
      data_not_address <= byte_is_data; // [R6]
    end
  end

  chk_byte_kind_follow: assert property ( // [R6]
    @(posedge clk_sys) disable iff (reset)
    (i2c_active && byte_done) |=> (data_not_address == $past(byte_is_data)))
    else $error("data or address flag did not follow the last byte");

  chk_byte_kind_hold: assert property ( // [R6]
    @(posedge clk_sys) disable iff (reset)
    !(i2c_active && byte_done) |=> $stable(data_not_address))
    else $error("data or address flag changed without a byte");

endmodule

// ===== spsc_status_bits.sv
/*
  Upper three bits of the serial port status register, with the port mode.
  Assumes a single clock, synchronous reset and an Avalon-MM master.
*/
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/10ps

// Behaviour
// R1: In SPI master mode, received data is sampled at the end of output time when the sample bit is set, else at its middle.
// R2: Software keeps the sample bit clear when the port is an SPI slave.
// R3: In I2C mode, slew rate control is off when the sample bit is set and on when it is clear.
// R4: In SPI mode, data shifts out on the active-to-idle clock edge when the edge bit is set, else on idle-to-active.
// R5: In I2C mode, the edge bit set selects SMBus input thresholds, clear selects normal thresholds.
// R6: In I2C mode, the read-only flag shows one after a data byte and zero after an address byte.
module spsc_status_bits (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic byte_done,
  input wire logic byte_is_data,
  output logic sample_at_end,
  output logic sample_at_middle,
  output logic slew_control_enable,
  output logic shift_on_active_to_idle,
  output logic smbus_thresholds
);
  import spsc_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  spsc_state_type state;
  spsc_state_type next_state;
  logic [1:0] port_mode;
  logic input_sample_point_select;
  logic clock_edge_select;
  logic data_not_address;
  logic [7:0] status_value;
  logic [31:0] next_readdata;

  wire access = avs_read | avs_write;
  wire hit_status = (avs_address == SPSC_STATUS_OFFSET);
  wire hit_mode = (avs_address == SPSC_MODE_OFFSET);
  wire hit_any = hit_status | hit_mode;
  wire take = access && (state == SPSC_IDLE);
  // Writes land on the answering edge, where the master sees waitrequest low
  wire commit = access && (state == SPSC_DONE);
  wire wr_status = commit && avs_write && hit_status && avs_byteenable[0];
  wire wr_mode = commit && avs_write && hit_mode && avs_byteenable[0];
  wire is_i2c = port_mode[1];
  wire is_spi_master = (port_mode == SPSC_MODE_SPI_MASTER);

  // Request accepted in idle, answered one cycle later
  assign avs_waitrequest = access && (state != SPSC_DONE);

  // Lower five status bits belong to the shift engine and read as zero here
  assign status_value = {input_sample_point_select, clock_edge_select, data_not_address,
                         5'h00};

  // Read data selection
  assign next_readdata = hit_status ? {24'h000000, status_value} :
                         hit_mode ? {30'h00000000, port_mode} : 32'h00000000;

  // ****************************************
  // Bus state machine
  // ****************************************
  always_comb begin
    case (state)
      SPSC_IDLE: next_state = take ? SPSC_DONE : SPSC_IDLE;
      SPSC_DONE: next_state = SPSC_IDLE;
      default: next_state = SPSC_IDLE;
    endcase
  end

  // State and read data registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SPSC_IDLE;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else begin
      state <= next_state;
      if (take) begin
        avs_readdata <= avs_read ? next_readdata : 32'h00000000;
        avs_response <= hit_any ? 2'h0 : 2'h2; // Unmapped address answers slave error
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      input_sample_point_select <= SPSC_STATUS_RESET[SPSC_SAMPLE_BIT];
      clock_edge_select <= SPSC_STATUS_RESET[SPSC_EDGE_BIT];
      port_mode <= SPSC_MODE_RESET;
    end else begin
      if (wr_status) begin
        input_sample_point_select <= avs_writedata[SPSC_SAMPLE_BIT];
        clock_edge_select <= avs_writedata[SPSC_EDGE_BIT];
      end
      if (wr_mode) begin
        port_mode <= avs_writedata[1:0];
      end
    end
  end

  // ****************************************
  // Data or address flag
  // ****************************************
  spsc_byte_kind u_byte_kind (
    .clk_sys(clk_sys),
    .reset(reset),
    .i2c_active(is_i2c),
    .byte_done(byte_done),
    .byte_is_data(byte_is_data),
    .data_not_address(data_not_address)
  );

  // ****************************************
  // Mode-steered controls to the shift engine and pads
  // ****************************************
  // Sample point only matters for SPI master; an SPI slave drives neither sample point
  assign sample_at_end = is_spi_master & input_sample_point_select; // [R1] [R2]
  assign sample_at_middle = is_spi_master & ~input_sample_point_select; // [R1]
  assign slew_control_enable = is_i2c & ~input_sample_point_select; // [R3]
  assign shift_on_active_to_idle = ~is_i2c & clock_edge_select; // [R4]
  assign smbus_thresholds = is_i2c & clock_edge_select; // [R5]

  chk_sample_point_end: assert property ( // [R1]
    @(posedge clk_sys) disable iff (reset)
    (is_spi_master && input_sample_point_select) |-> (sample_at_end && !sample_at_middle))
    else $error("SPI master did not sample at end");

  chk_slew_after_write: assert property ( // [R3]
    @(posedge clk_sys) disable iff (reset)
    (wr_status && is_i2c && !wr_mode) |=> (slew_control_enable == !$past(avs_writedata[7])))
    else $error("slew control did not follow written sample bit");

  chk_edge_after_write: assert property ( // [R4]
    @(posedge clk_sys) disable iff (reset)
    (wr_status && !is_i2c && !wr_mode) |=>
      (shift_on_active_to_idle == $past(avs_writedata[6])))
    else $error("shift edge did not follow written edge bit");

  chk_smbus_thresh_mode: assert property ( // [R5]
    @(posedge clk_sys) disable iff (reset)
    smbus_thresholds |-> (is_i2c && clock_edge_select && !shift_on_active_to_idle))
    else $error("SMBus thresholds outside I2C edge bit");

  chk_bus_answer_next: assert property (
    @(posedge clk_sys) disable iff (reset)
    (access && state == SPSC_IDLE) |=> !avs_waitrequest)
    else $error("bus answer not given next cycle");

  chk_read_status_bits: assert property ( // [R6]
    @(posedge clk_sys) disable iff (reset)
    (take && avs_read && hit_status) |=> (avs_readdata[5] == $past(data_not_address)))
    else $error("read of status lost data or address flag");

  // ****************************************
  // Bus checks
  // ****************************************
  // A write must wait for the answer edge, never land on the acceptance edge
  chk_write_waits_answer: assert property (
    @(posedge clk_sys) disable iff (reset)
    (take && avs_write) |=>
      ($stable(input_sample_point_select) && $stable(clock_edge_select) && $stable(port_mode)))
    else $error("write landed before waitrequest dropped");

  // Read data and response stand between accepted requests
  chk_answer_stands: assert property (
    @(posedge clk_sys) disable iff (reset)
    !take |=> ($stable(avs_readdata) && $stable(avs_response)))
    else $error("read data or response changed without a request");

  // Unmapped places answer slave error with zero data
  chk_unmapped_refused: assert property (
    @(posedge clk_sys) disable iff (reset)
    (take && !hit_any) |=> (avs_response == 2'h2 && avs_readdata == 32'h00000000))
    else $error("unmapped access not refused");

  // Unmapped places change no register
  chk_unmapped_no_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (access && !hit_any) |=>
      ($stable(input_sample_point_select) && $stable(clock_edge_select) && $stable(port_mode)))
    else $error("unmapped write changed a register");

  // Mapped places always answer okay
  chk_mapped_okay: assert property (
    @(posedge clk_sys) disable iff (reset)
    (take && hit_any) |=> (avs_response == 2'h0))
    else $error("mapped access not answered okay");

  // ****************************************
  // Mode control checks
  // ****************************************
  // SPI master sample point follows the written bit in both directions
  chk_sample_after_write: assert property ( // [R1]
    @(posedge clk_sys) disable iff (reset)
    (wr_status && is_spi_master) |=>
      (sample_at_end == $past(avs_writedata[SPSC_SAMPLE_BIT]) &&
       sample_at_middle == !$past(avs_writedata[SPSC_SAMPLE_BIT])))
    else $error("SPI master sample point did not follow written bit");

  // SPI slave leaves sampling to the engine's fixed point
  chk_slave_sample_idle: assert property ( // [R1] [R2]
    @(posedge clk_sys) disable iff (reset)
    (port_mode == SPSC_MODE_SPI_SLAVE) |-> !(sample_at_end || sample_at_middle))
    else $error("SPI slave drove a master sample point");

  // SMBus thresholds follow the written edge bit in I2C
  chk_smbus_after_write: assert property ( // [R5]
    @(posedge clk_sys) disable iff (reset)
    (wr_status && is_i2c) |=> (smbus_thresholds == $past(avs_writedata[SPSC_EDGE_BIT])))
    else $error("SMBus thresholds did not follow written edge bit");

endmodule

// ===== spsc_peer.sv
/* Bus peer model: byte completion strobes from the I2C shift side.
   Assumes the testbench calls send from its main sequence. */
`timescale 1ns/10ps
module spsc_peer (
  input wire logic clk_sys,
  output logic byte_done,
  output logic byte_is_data
);
  initial begin
    byte_done = 1'b0;
    byte_is_data = 1'b1;
  end
  // One-cycle strobe; kind line shows the inverse once the strobe is over
  task send(input logic is_data);
    @(posedge clk_sys);
    byte_done <= 1'b1;
    byte_is_data <= is_data;
    @(posedge clk_sys);
    byte_done <= 1'b0;
    byte_is_data <= !is_data;
  endtask
endmodule

// ===== spsc_status_bits_tb.sv
/* Testbench for the status bits block: mode table, byte kind, bus refusal.
   Assumes the package and the peer model are compiled first. */
`timescale 1ns/10ps
module spsc_status_bits_tb;
  import spsc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic [1:0] avs_response, r;
  logic avs_waitrequest, byte_done, byte_is_data;
  logic sample_at_end, sample_at_middle, slew_control_enable;
  logic shift_on_active_to_idle, smbus_thresholds;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ****************************************
  // Clock, peer and block
  // ****************************************
  always #10 clk_sys = ~clk_sys;
  spsc_peer peer (.clk_sys(clk_sys), .byte_done(byte_done), .byte_is_data(byte_is_data));
  spsc_status_bits dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .byte_done(byte_done), .byte_is_data(byte_is_data),
    .sample_at_end(sample_at_end), .sample_at_middle(sample_at_middle),
    .slew_control_enable(slew_control_enable), .smbus_thresholds(smbus_thresholds),
    .shift_on_active_to_idle(shift_on_active_to_idle));
  // Compare and count
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    bus(1'b0, SPSC_STATUS_OFFSET, 32'h0);
    check("status", {24'h0, SPSC_STATUS_RESET}, q);
    bus(1'b0, SPSC_MODE_OFFSET, 32'h0);
    check("mode", {30'h0, SPSC_MODE_RESET}, q);
    $display("test reset done");
  endtask
  // Every mode against every setting of the two writable bits, except SPI slave with the sample bit set
  task t_modes;
    logic [1:0] m;
    logic [7:0] s;
    logic [4:0] e;
    for (int i = 0; i < 16; i++) begin
      m = i[3:2];
      s = {i[1:0], 6'h0};
      if (m == SPSC_MODE_SPI_SLAVE && s[7]) continue;
      bus(1'b1, SPSC_MODE_OFFSET, {30'h0, m});
      bus(1'b1, SPSC_STATUS_OFFSET, {24'h0, s | 8'h3F});
      bus(1'b0, SPSC_STATUS_OFFSET, 32'h0);
      check("status", {24'h0, s}, q);
      @(negedge clk_sys);
      e = {m == SPSC_MODE_SPI_MASTER && s[7], m == SPSC_MODE_SPI_MASTER && !s[7],
        m[1] && !s[7], !m[1] && s[6], m[1] && s[6]};
      check("select", {27'h0, e}, {27'h0, sample_at_end, sample_at_middle,
        slew_control_enable, shift_on_active_to_idle, smbus_thresholds});
    end
    $display("test modes done");
  endtask
  // Byte strobe in a given mode, then status read back
  task kind(input logic [1:0] m, input logic d, input logic [7:0] exp);
    bus(1'b1, SPSC_MODE_OFFSET, {30'h0, m});
    peer.send(d);
    bus(1'b0, SPSC_STATUS_OFFSET, 32'h0);
    check("byte_kind", {24'h0, exp}, q);
  endtask
  task t_kind;
    kind(SPSC_MODE_I2C_MASTER, 1'b1, 8'hE0);
    kind(SPSC_MODE_SPI_MASTER, 1'b0, 8'hE0);
    kind(SPSC_MODE_I2C_SLAVE, 1'b0, 8'hC0);
    $display("test kind done");
  endtask
  // Unmapped place: error response, zero data, no write
  task t_unmapped;
    bus(1'b1, 4'h8, 32'hFF);
    check("wr_resp", 32'h2, {30'h0, r});
    bus(1'b0, 4'h8, 32'h0);
    check("rd_resp", 32'h2, {30'h0, r});
    check("rd_data", 32'h0, q);
    bus(1'b0, SPSC_STATUS_OFFSET, 32'h0);
    check("status", 32'hC0, q);
    $display("test unmapped done");
  endtask
  // Byte lane 0 off: the status write is dropped
  task t_lanes;
    avs_byteenable <= 4'hE;
    bus(1'b1, SPSC_STATUS_OFFSET, 32'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, SPSC_STATUS_OFFSET, 32'h0);
    check("lane_off", 32'hC0, q);
    $display("test lanes done");
  endtask
  // Reset in mid-run: SPI master, sample bit clear, so only the middle point is on
  task t_restart;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check("rst_select", 32'h8, {27'h0, sample_at_end, sample_at_middle,
      slew_control_enable, shift_on_active_to_idle, smbus_thresholds});
    t_reset;
    $display("test restart done");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_modes;
    t_kind;
    t_unmapped;
    t_lanes;
    t_restart;
    give_verdict;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict;
    end
  end
endmodule
